// [src/mii_phy_data_port.sv]
// Nibble-wide MII data port of a 10/100 PHY, facing a MAC.
// Assumes a decoded 5-bit code group stream from the line side,
// a recovered line clock pin, and MII pins from the MAC.
`timescale 1ns/1ps
// Contract
// R01: RXD bit 0 is least significant.
// R02: RXD changes at RXCLK rising edges.
// R03: RXDV rises only after J then K.
// R04: RXDV falls on T/R or signal error.
// R05: RXDV changes only with receive clock.
// R06: RXER unused in 10 Mb/s mode.
// R07: RXER on frame error or false carrier.
// R08: RXER changes only with receive clock.
// R09: RXER conditioned by tristate request.
// R10: Tristate request high releases receive pins.
// R11: MAC drives tristate request per condition.
// R12: TXCLK generated: 2.5 or 25 MHz.
// R13: TXD bit 0 is least significant.
// R14: TXD sampled at TXCLK rise under TXEN.
// R15: Sampled nibbles sent in order.
// R16: Transmission ends after TXEN falls.
// R17: TXER ignored in 10 Mb/s mode.
// R18: TXER sampled at TXCLK rise in 100.
// R19: TXER sends HALT instead of nibble.
// R20: Test bit selects alternate error code.
// R21: RXCLK from line when linked, else reference.
// R22: Alternate error code is a parameter.
module mii_phy_data_port #(
  parameter logic [4:0] ALT_ERR_CODE = 5'h08,
  parameter int         RX_DEPTH     = mii_port_pkg::RX_BUF_DEPTH
) (
  // Clock, reset, enable
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_ce,
  // Mode and control
  input  wire logic       i_speed_100,
  input  wire logic       i_link_up,
  input  wire logic       i_invalid_code_test,
  // Line receive stream
  input  wire logic       i_line_clk,
  input  wire logic [4:0] i_rx_sym,
  input  wire logic       i_rx_sym_valid,
  output logic            o_rx_sym_ready,
  // MII receive pins
  output logic            o_rxclk,
  output logic [3:0]      o_rxd,
  output logic            o_rxdv,
  output logic            o_rxer,
  output logic            o_rx_oe,
  input  wire logic       i_receive_tristate_request,
  // MII transmit pins
  output logic            o_txclk,
  input  wire logic [3:0] i_txd,
  input  wire logic       i_txen,
  input  wire logic       i_txer,
  // Line transmit stream
  output logic [4:0]      o_tx_sym,
  output logic            o_tx_sym_valid,
  output logic            o_tx_active
);
  localparam int DW = mii_port_pkg::DIV_W;
  localparam int EW = mii_port_pkg::RX_ENTRY_W;

  typedef struct packed {
    logic                    line_s1;
    logic                    line_s2;
    logic                    tri_s1;
    logic                    tri_s2;
    logic [3:0]              txd_s1;
    logic [3:0]              txd_s2;
    logic                    txen_s1;
    logic                    txen_s2;
    logic                    txer_s1;
    logic                    txer_s2;
    logic [DW-1:0]           rx_div;
    logic [DW-1:0]           tx_div;
    logic                    rxclk;
    logic                    txclk;
    mii_port_pkg::rx_state_t rx_state;
    mii_port_pkg::tx_state_t tx_state;
    logic [3:0]              rxd;
    logic                    rxdv;
    logic                    rxer;
    logic                    rx_oe;
    logic [4:0]              tx_sym;
    logic                    tx_sym_valid;
  } port_state_t;

  port_state_t   st_reg;
  port_state_t   st_next;
  logic          rx_tick;
  logic          tx_rise;
  logic          sym_take;
  logic [4:0]    dec;
  logic          push_valid;
  logic [EW-1:0] push_data;
  logic          buf_in_ready;
  logic [EW-1:0] buf_out_data;
  logic          buf_out_valid;
  logic [4:0]    err_sym;
  logic [4:0]    data_sym;

  // Receive entries wait here until the next RXCLK rise
  mii_rx_buffer #(
    .W     (EW),
    .DEPTH (RX_DEPTH)
  ) u_rx_buffer (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_ce        (i_ce),
    .i_in_data   (push_data),
    .i_in_valid  (push_valid),
    .o_in_ready  (buf_in_ready),
    .o_out_data  (buf_out_data),
    .o_out_valid (buf_out_valid),
    .i_out_ready (rx_tick)
  );

  // Source stalls whenever the buffer is full
  assign o_rx_sym_ready = buf_in_ready && i_ce;

  // Pin outputs straight from the state register
  assign o_rxclk = st_reg.rxclk;
  assign o_rxd = st_reg.rxd;
  assign o_rxdv = st_reg.rxdv;
  assign o_rxer = st_reg.rxer;
  assign o_rx_oe = st_reg.rx_oe;
  assign o_txclk = st_reg.txclk;
  assign o_tx_sym = st_reg.tx_sym;
  assign o_tx_sym_valid = st_reg.tx_sym_valid;
  assign o_tx_active = (st_reg.tx_state != mii_port_pkg::TX_IDLE);

  // All next-state logic
  always_comb
  begin
    st_next = st_reg;
    rx_tick = 1'b0;
    tx_rise = 1'b0;
    push_valid = 1'b0;
    push_data = '0;
    sym_take = i_rx_sym_valid && buf_in_ready && i_ce;
    dec = mii_port_pkg::decode_symbol(i_rx_sym);
    err_sym = i_invalid_code_test ? ALT_ERR_CODE : mii_port_pkg::SYM_HALT; // R20 R22
    data_sym = (i_speed_100 && st_reg.txer_s2) ? err_sym // R17 R18 R19
             : mii_port_pkg::encode_nibble(st_reg.txd_s2); // R13
    if (i_ce)
    begin
      // Pin synchronisers
      st_next.line_s1 = i_line_clk;
      st_next.line_s2 = st_reg.line_s1;
      st_next.tri_s1 = i_receive_tristate_request;
      st_next.tri_s2 = st_reg.tri_s1;
      st_next.txd_s1 = i_txd;
      st_next.txd_s2 = st_reg.txd_s1;
      st_next.txen_s1 = i_txen;
      st_next.txen_s2 = st_reg.txen_s1;
      st_next.txer_s1 = i_txer;
      st_next.txer_s2 = st_reg.txer_s1;
      // Release the receive pins while the MAC is tristated
      st_next.rx_oe = !st_reg.tri_s2; // R09 R10

      // Receive clock source
      if (i_link_up)
      begin
        st_next.rxclk = st_reg.line_s2; // R21
        st_next.rx_div = mii_port_pkg::half_count(i_speed_100);
      end
      else if (st_reg.rx_div == '0)
      begin
        st_next.rxclk = !st_reg.rxclk; // R21
        st_next.rx_div = mii_port_pkg::half_count(i_speed_100);
      end
      else
      begin
        st_next.rx_div = st_reg.rx_div - 1'b1;
      end
      rx_tick = st_next.rxclk && !st_reg.rxclk;

      // Receive pins move only at an RXCLK rise
      if (rx_tick)
      begin
        if (buf_out_valid)
        begin
          st_next.rxd = buf_out_data[3:0]; // R01 R02
          st_next.rxdv = buf_out_data[mii_port_pkg::RX_DV_BIT]; // R05
          st_next.rxer = buf_out_data[mii_port_pkg::RX_ER_BIT]
                       && i_speed_100; // R06 R08
        end
        else
        begin
          st_next.rxdv = 1'b0;
          st_next.rxer = 1'b0;
        end
      end

      // Stream delimiter and data decoding
      if (!i_link_up)
      begin
        st_next.rx_state = mii_port_pkg::RX_IDLE;
      end
      else if (sym_take)
      begin
        unique case (st_reg.rx_state)
          mii_port_pkg::RX_IDLE:
          begin
            if (i_rx_sym == mii_port_pkg::SYM_J)
            begin
              st_next.rx_state = mii_port_pkg::RX_GOT_J;
            end
            else if (i_rx_sym != mii_port_pkg::SYM_IDLE)
            begin
              push_valid = 1'b1; // R07
              push_data = {2'b01, mii_port_pkg::FALSE_CARRIER_NIB};
            end
          end
          mii_port_pkg::RX_GOT_J:
          begin
            if (i_rx_sym == mii_port_pkg::SYM_K)
            begin
              st_next.rx_state = mii_port_pkg::RX_FRAME; // R03
            end
            else
            begin
              push_valid = 1'b1; // R07
              push_data = {2'b01, mii_port_pkg::FALSE_CARRIER_NIB};
              st_next.rx_state = mii_port_pkg::RX_IDLE;
            end
          end
          mii_port_pkg::RX_FRAME:
          begin
            if (i_rx_sym == mii_port_pkg::SYM_T)
            begin
              st_next.rx_state = mii_port_pkg::RX_GOT_T;
            end
            else if (dec[4])
            begin
              push_valid = 1'b1; // R02 R03
              push_data = {2'b10, dec[3:0]};
            end
            else
            begin
              push_valid = 1'b1; // R04 R07
              push_data = {2'b11, 4'h0};
              st_next.rx_state = mii_port_pkg::RX_IDLE;
            end
          end
          mii_port_pkg::RX_GOT_T:
          begin
            if (i_rx_sym != mii_port_pkg::SYM_R)
            begin
              push_valid = 1'b1; // R04 R07
              push_data = {2'b11, 4'h0};
            end
            st_next.rx_state = mii_port_pkg::RX_IDLE; // R04
          end
        endcase
      end

      // Transmit clock divider
      if (st_reg.tx_div == '0)
      begin
        st_next.txclk = !st_reg.txclk; // R12
        st_next.tx_div = mii_port_pkg::half_count(i_speed_100);
      end
      else
      begin
        st_next.tx_div = st_reg.tx_div - 1'b1;
      end
      tx_rise = st_next.txclk && !st_reg.txclk;

      // Transmit sampling and code group output
      st_next.tx_sym_valid = 1'b0;
      if (tx_rise)
      begin
        unique case (st_reg.tx_state)
          mii_port_pkg::TX_IDLE:
          begin
            if (st_reg.txen_s2)
            begin
              st_next.tx_sym = data_sym; // R14 R15
              st_next.tx_sym_valid = 1'b1;
              st_next.tx_state = mii_port_pkg::TX_DATA;
            end
          end
          mii_port_pkg::TX_DATA:
          begin
            st_next.tx_sym_valid = 1'b1;
            if (st_reg.txen_s2)
            begin
              st_next.tx_sym = data_sym; // R14 R15
            end
            else
            begin
              st_next.tx_sym = mii_port_pkg::SYM_T; // R16
              st_next.tx_state = mii_port_pkg::TX_END_T;
            end
          end
          mii_port_pkg::TX_END_T:
          begin
            st_next.tx_sym = mii_port_pkg::SYM_R; // R16
            st_next.tx_sym_valid = 1'b1;
            st_next.tx_state = mii_port_pkg::TX_IDLE;
          end
          default:
          begin
            st_next.tx_state = mii_port_pkg::TX_IDLE;
          end
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst || !i_ce);

  sequence s_tx_err_rise;
    tx_rise && st_reg.txen_s2 && i_speed_100 && st_reg.txer_s2
      && (st_reg.tx_state != mii_port_pkg::TX_END_T);
  endsequence

  sequence s_tx_stop;
    tx_rise && !st_reg.txen_s2 && (st_reg.tx_state == mii_port_pkg::TX_DATA);
  endsequence

  chk_rxd_edge: assert property ( // R02
    $changed(o_rxd) |-> $rose(o_rxclk))
    else $error("receive nibble moved off an RXCLK rise");

  chk_rxdv_edge: assert property ( // R05
    $changed(o_rxdv) |-> $rose(o_rxclk))
    else $error("RXDV moved off an RXCLK rise");

  chk_rxer_edge: assert property ( // R08
    $changed(o_rxer) |-> $rose(o_rxclk))
    else $error("RXER moved off an RXCLK rise");

  chk_rxer_slow_mode: assert property ( // R06
    $rose(o_rxclk) && !$past(i_speed_100) |-> !o_rxer)
    else $error("RXER raised in 10 Mb/s mode");

  chk_rx_tristate: assert property ( // R10
    i_receive_tristate_request [*3] |=> !o_rx_oe)
    else $error("receive pins still driven while tristated");

  chk_dv_needs_jk: assert property ( // R03
    push_valid && push_data[mii_port_pkg::RX_DV_BIT]
      |-> st_reg.rx_state inside {mii_port_pkg::RX_FRAME, mii_port_pkg::RX_GOT_T})
    else $error("frame data before start delimiter");

  chk_err_ends_frame: assert property ( // R04
    sym_take && i_link_up && (st_reg.rx_state == mii_port_pkg::RX_FRAME)
      && !dec[4] && (i_rx_sym != mii_port_pkg::SYM_T)
      |=> st_reg.rx_state == mii_port_pkg::RX_IDLE)
    else $error("frame kept open after signal error");

  chk_false_carrier: assert property ( // R07
    sym_take && i_link_up && (st_reg.rx_state == mii_port_pkg::RX_GOT_J)
      && (i_rx_sym != mii_port_pkg::SYM_K)
      |-> push_valid && push_data[mii_port_pkg::RX_ER_BIT])
    else $error("false carrier not flagged");

  chk_txclk_fast: assert property ( // R12
    ($rose(o_txclk) && i_speed_100 && $past(i_speed_100)) ##1 i_speed_100 [*3]
      |=> $rose(o_txclk))
    else $error("TXCLK not 25 MHz");

  chk_txclk_slow: assert property ( // R12
    ($rose(o_txclk) && !i_speed_100 && !$past(i_speed_100)) ##1 !i_speed_100 [*8]
      |-> o_txclk)
    else $error("TXCLK high phase too short at 2.5 MHz");

  chk_tx_halt: assert property ( // R19
    s_tx_err_rise ##0 !i_invalid_code_test
      |=> o_tx_sym_valid && (o_tx_sym == mii_port_pkg::SYM_HALT))
    else $error("HALT not substituted on TXER");

  chk_tx_alt_code: assert property ( // R20
    s_tx_err_rise ##0 i_invalid_code_test
      |=> o_tx_sym_valid && (o_tx_sym == ALT_ERR_CODE))
    else $error("alternate code not substituted");

  chk_txer_ignored: assert property ( // R17
    tx_rise && st_reg.txen_s2 && !i_speed_100
      && (st_reg.tx_state != mii_port_pkg::TX_END_T)
      |=> o_tx_sym == mii_port_pkg::encode_nibble($past(st_reg.txd_s2)))
    else $error("TXER acted in 10 Mb/s mode");

  chk_tx_end: assert property ( // R16
    s_tx_stop |=> (o_tx_sym == mii_port_pkg::SYM_T)
      ##[1:40] (o_tx_sym_valid && (o_tx_sym == mii_port_pkg::SYM_R)))
    else $error("transmission not closed after TXEN fell");

  chk_rxclk_source: assert property ( // R21
    i_link_up [*4] |-> o_rxclk == $past(i_line_clk, 3))
    else $error("RXCLK not following the line clock");
endmodule

// [src/mii_port_pkg.sv]
// Constants, types and code tables of the MII data port.
// Assumes a 100 MHz system clock drives every process.
package mii_port_pkg;
  // System clock and MII transmit clock rates
  localparam int CLK_FREQ_KHZ = 100000;
  localparam int TXCLK_100_KHZ = 25000;
  localparam int TXCLK_10_KHZ = 2500;
  localparam int HALF_100 = CLK_FREQ_KHZ / (2 * TXCLK_100_KHZ);
  localparam int HALF_10 = CLK_FREQ_KHZ / (2 * TXCLK_10_KHZ);
  localparam int DIV_W = 5;
  localparam logic [DIV_W-1:0] HALF_100_CNT = DIV_W'(HALF_100 - 1);
  localparam logic [DIV_W-1:0] HALF_10_CNT = DIV_W'(HALF_10 - 1);

  // Control code groups and false carrier nibble
  localparam logic [4:0] SYM_J = 5'h18;
  localparam logic [4:0] SYM_K = 5'h11;
  localparam logic [4:0] SYM_T = 5'h0d;
  localparam logic [4:0] SYM_R = 5'h07;
  localparam logic [4:0] SYM_IDLE = 5'h1f;
  localparam logic [4:0] SYM_HALT = 5'h04;
  localparam logic [3:0] FALSE_CARRIER_NIB = 4'he;

  // Receive buffer entry layout: {dv, er, nibble}
  localparam int RX_ENTRY_W = 6;
  localparam int RX_DV_BIT = 5;
  localparam int RX_ER_BIT = 4;
  localparam int RX_BUF_DEPTH = 2;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_GOT_J = 2'b01,
    RX_FRAME = 2'b10,
    RX_GOT_T = 2'b11
  } rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_DATA  = 2'b01,
    TX_END_T = 2'b10
  } tx_state_t;

  localparam logic [4:0] CODE_TABLE [16] = '{
    5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

  // Nibble to data code group
  function automatic logic [4:0] encode_nibble(input logic [3:0] nib);
    encode_nibble = CODE_TABLE[nib];
  endfunction

  // Code group to {valid, nibble}
  function automatic logic [4:0] decode_symbol(input logic [4:0] sym);
    decode_symbol = 5'h00;
    for (int i = 0; i < 16; i++)
    begin
      if (CODE_TABLE[i] == sym)
      begin
        decode_symbol = {1'b1, 4'(i)};
      end
    end
  endfunction

  // Half period reload of a clock divider for the mode
  function automatic logic [DIV_W-1:0] half_count(input logic fast);
    half_count = fast ? HALF_100_CNT : HALF_10_CNT;
  endfunction
endpackage

// [src/mii_rx_buffer.sv]
// Small valid/ready buffer for receive entries.
// Assumes the same clock, reset and clock enable as its parent.
`timescale 1ns/1ps
module mii_rx_buffer #(
  parameter int W     = 6,
  parameter int DEPTH = 2
) (
  // Clock, reset and clock enable
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  // Fill side
  input  wire logic [W-1:0] i_in_data,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  // Drain side
  output logic [W-1:0]      o_out_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wr_ptr;
    logic [PW-1:0]           rd_ptr;
    logic [CW-1:0]           count;
  } buf_state_t;

  buf_state_t st_reg;
  buf_state_t st_next;
  logic       push;
  logic       pop;

  // Pointer step with wrap at the depth
  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    step = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Honest flags straight from the count
  assign o_in_ready = (st_reg.count != CW'(DEPTH));
  assign o_out_valid = (st_reg.count != '0);
  assign o_out_data = st_reg.mem[st_reg.rd_ptr];

  // Next state of the buffer
  always_comb
  begin
    st_next = st_reg;
    push = i_ce && i_in_valid && o_in_ready;
    pop = i_ce && i_out_ready && o_out_valid;
    if (push)
    begin
      st_next.mem[st_reg.wr_ptr] = i_in_data;
      st_next.wr_ptr = step(st_reg.wr_ptr);
    end
    if (pop)
    begin
      st_next.rd_ptr = step(st_reg.rd_ptr);
    end
    if (push && !pop)
    begin
      st_next.count = st_reg.count + 1'b1;
    end
    else if (pop && !push)
    begin
      st_next.count = st_reg.count - 1'b1;
    end
  end

  // State register
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  chk_buf_no_overflow: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_reg.count == CW'(DEPTH)) && !pop |=> st_reg.count == CW'(DEPTH))
    else $error("receive buffer count moved while full");
endmodule

// [dv/mac_model.sv]
// MAC side model of the MII data port: drives transmit nibbles, records receive entries.
// Assumes TXCLK and RXCLK come from the port and change just after the system clock edge.
`timescale 1ns/1ps
module mac_model (
  // Port clocks and receive pins
  input  wire logic       i_txclk,
  input  wire logic       i_rxclk,
  input  wire logic [3:0] i_rxd,
  input  wire logic       i_rxdv,
  input  wire logic       i_rxer,
  // Transmit pins
  output logic [3:0]      o_txd,
  output logic            o_txen,
  output logic            o_txer
);
  // Nibbles to send as {error, nibble}; entries seen as {dv, er, nibble}
  logic [4:0] tx_q [$];
  logic [5:0] rx_q [$];
  logic [4:0] item;

  // Quiet transmit pins at start
  initial
  begin
    o_txd  = 4'h0;
    o_txen = 1'b0;
    o_txer = 1'b0;
  end

  // New nibble just after each TXCLK rise, held for a whole period
  always @(posedge i_txclk)
  begin
    #1;
    if (tx_q.size() > 0)
    begin
      item   = tx_q.pop_front();
      o_txen = 1'b1;
      o_txd  = item[3:0];
      o_txer = item[4];
    end
    else
    begin
      o_txen = 1'b0;
      o_txer = 1'b0;
      o_txd  = ~o_txd; // Idle data keeps moving, never stale
    end
  end

  // Record each non-empty receive entry once the RXCLK rise has landed
  always @(posedge i_rxclk)
  begin
    #1;
    if (i_rxdv === 1'b1 || i_rxer === 1'b1)
      rx_q.push_back({i_rxdv, i_rxer, i_rxd});
  end
endmodule

// [dv/tb_mii_phy_data_port.sv]
// Self-checking bench of the MII data port against queue-based models.
// Assumes the port package and design files are compiled first.
`timescale 1ns/1ps
module tb_mii_phy_data_port;
  localparam logic [4:0] ALT_CODE = 5'h19;
  localparam logic [4:0] ENC [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b,
    5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  // Stimulus, outputs and bench state
  logic       i_clk = 0, i_rst = 1, i_ce = 1, i_speed_100 = 1, i_link_up = 1;
  logic       i_invalid_code_test = 0, i_line_clk = 0, i_rx_sym_valid = 0;
  logic       i_receive_tristate_request = 0;
  logic [4:0] i_rx_sym = 5'h00;
  logic       o_rx_sym_ready, o_rxclk, o_rxdv, o_rxer, o_rx_oe, o_txclk;
  logic       o_tx_sym_valid, o_tx_active, txen, txer;
  logic [3:0] o_rxd, txd;
  logic [4:0] o_tx_sym;
  logic [6:0] exp_rx [$];
  logic [4:0] exp_tx [$], got_tx [$];
  int         miscompares = 0, samples_checked = 0, full_seen = 0, per;

  // Clocks: system 10 ns, line 125 ns of unrelated phase
  always #5 i_clk = ~i_clk;
  // Offset so line edges never meet a system clock edge
  initial
  begin
    #3;
    forever #62.5 i_line_clk = ~i_line_clk;
  end

  mii_phy_data_port #(.ALT_ERR_CODE(ALT_CODE)) dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_speed_100(i_speed_100),
    .i_link_up(i_link_up), .i_invalid_code_test(i_invalid_code_test),
    .i_line_clk(i_line_clk), .i_rx_sym(i_rx_sym), .i_rx_sym_valid(i_rx_sym_valid),
    .o_rx_sym_ready(o_rx_sym_ready), .o_rxclk(o_rxclk), .o_rxd(o_rxd), .o_rxdv(o_rxdv),
    .o_rxer(o_rxer), .o_rx_oe(o_rx_oe),
    .i_receive_tristate_request(i_receive_tristate_request), .o_txclk(o_txclk),
    .i_txd(txd), .i_txen(txen), .i_txer(txer), .o_tx_sym(o_tx_sym),
    .o_tx_sym_valid(o_tx_sym_valid), .o_tx_active(o_tx_active));

  mac_model mac (
    .i_txclk(o_txclk), .i_rxclk(o_rxclk), .i_rxd(o_rxd), .i_rxdv(o_rxdv),
    .i_rxer(o_rxer), .o_txd(txd), .o_txen(txen), .o_txer(txer));

  // Emitted code groups, one per valid pulse, read mid-cycle
  always @(negedge i_clk)
    if (o_tx_sym_valid === 1'b1)
      got_tx.push_back(o_tx_sym);

  task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Data code group to nibble, -1 if not a data code
  function automatic int dec(input logic [4:0] s);
    dec = -1;
    for (int i = 0; i < 16; i++)
      if (ENC[i] == s)
        dec = i;
  endfunction

  // Receive model: entries {nibble ignored, dv, er, nibble}
  function automatic void rx_model(input logic [4:0] s [$], input bit sp);
    int st = 0;
    foreach (s[i])
    begin
      if (st == 0 && s[i] == mii_port_pkg::SYM_J)
        st = 1;
      else if ((st == 0 && s[i] != mii_port_pkg::SYM_IDLE) || st == 1)
      begin
        if (st == 1 && s[i] == mii_port_pkg::SYM_K)
          st = 2;
        else
        begin
          st = 0;
          if (sp)
            exp_rx.push_back({3'b001, mii_port_pkg::FALSE_CARRIER_NIB});
        end
      end
      else if (st == 2 && s[i] == mii_port_pkg::SYM_T)
        st = 3;
      else if (st == 2 && dec(s[i]) >= 0)
        exp_rx.push_back({3'b010, 4'(dec(s[i]))});
      else if (st == 2 || (st == 3 && s[i] != mii_port_pkg::SYM_R))
      begin
        st = 0;
        exp_rx.push_back({2'b11, sp, 4'h0});
      end
      else if (st == 3)
        st = 0;
    end
  endfunction

  // Line stream: each code group held until taken
  task automatic send(input logic [4:0] s [$]);
    int n;
    foreach (s[i])
    begin
      i_rx_sym = s[i];
      i_rx_sym_valid = 1'b1;
      // Ready is settled here and decides the coming edge
      for (n = 0; n < 2000 && o_rx_sym_ready !== 1'b1; n++)
      begin
        @(posedge i_clk);
        #1;
      end
      full_seen += (n > 0);
      @(posedge i_clk);
      #1;
    end
    i_rx_sym_valid = 1'b0;
    i_rx_sym = ~i_rx_sym;
  endtask

  // Kinds: 0 good frame, 1 invalid code in frame, 2 false carrier, 3 J without K
  task automatic rx_case(input int kind);
    logic [4:0] s [$];
    logic [5:0] g;
    int n;
    s = {mii_port_pkg::SYM_IDLE, mii_port_pkg::SYM_J};
    if (kind < 2)
    begin
      s.push_back(mii_port_pkg::SYM_K);
      repeat ($urandom_range(8, 3)) s.push_back(ENC[$urandom_range(15)]);
      s.push_back((kind == 0) ? mii_port_pkg::SYM_T : 5'h00);
      s.push_back((kind == 0) ? mii_port_pkg::SYM_R : 5'h1f);
    end
    else
      s[1] = (kind == 2) ? ENC[$urandom_range(15)] : s[1];
    s.push_back(mii_port_pkg::SYM_IDLE);
    rx_model(s, i_speed_100);
    send(s);
    for (n = 0; n < 3000 && mac.rx_q.size() < exp_rx.size(); n++) @(posedge i_clk);
    repeat (60) @(posedge i_clk);
    check("rx_count", 8'(mac.rx_q.size()), 8'(exp_rx.size()));
    foreach (exp_rx[i])
    begin
      g = (i < mac.rx_q.size()) ? mac.rx_q[i] : 6'h3f;
      check("rx_flags", 8'(g[5:4]), 8'(exp_rx[i][5:4]));
      if (!exp_rx[i][6])
        check("rxd", 8'(g[3:0]), 8'(exp_rx[i][3:0]));
    end
    exp_rx.delete();
    mac.rx_q.delete();
    #1;
  endtask

  // Transmit frame of random nibbles, errors flagged when e is set
  task automatic tx_case(input bit e);
    logic [4:0] it;
    int n;
    repeat ($urandom_range(8, 3))
    begin
      it = {e & 1'($urandom_range(1)), 4'($urandom_range(15))};
      it[4] = it[4] | (e && mac.tx_q.size() == 1);
      mac.tx_q.push_back(it);
      if (it[4] && i_speed_100)
        exp_tx.push_back(i_invalid_code_test ? ALT_CODE : mii_port_pkg::SYM_HALT);
      else
        exp_tx.push_back(ENC[it[3:0]]);
    end
    exp_tx = {exp_tx, mii_port_pkg::SYM_T, mii_port_pkg::SYM_R};
    for (n = 0; n < 9000 && got_tx.size() < exp_tx.size(); n++) @(posedge i_clk);
    repeat (100) @(posedge i_clk);
    #1;
    check("tx_count", 8'(got_tx.size()), 8'(exp_tx.size()));
    foreach (exp_tx[i])
      check("tx_sym", (i < got_tx.size()) ? 8'(got_tx[i]) : 8'hff, 8'(exp_tx[i]));
    check("tx_active", 8'(o_tx_active), 8'h00);
    exp_tx.delete();
    got_tx.delete();
  endtask

  // Cycles between two rises of TXCLK or RXCLK
  task automatic measure(input bit rx, output int p);
    int t0 = -1;
    logic prev = 1'b1;
    logic cur;
    p = 0;
    for (int n = 0; n < 300 && p == 0; n++)
    begin
      @(posedge i_clk);
      #1;
      cur = rx ? o_rxclk : o_txclk;
      if (cur === 1'b1 && prev === 1'b0)
      begin
        if (t0 >= 0)
          p = n - t0;
        t0 = n;
      end
      prev = cur;
    end
  endtask

  // Main sequence: both speeds, then test code, tristate and local receive clock
  initial
  begin
    void'($urandom(65));
    repeat (3) @(posedge i_clk);
    #1 i_rst = 1'b0;
    for (int m = 0; m < 2; m++)
    begin
      i_speed_100 = (m == 0);
      measure(0, per);
      check("txclk_period", 8'(per), i_speed_100 ? 8'h04 : 8'h28);
      for (int k = 0; k < 4; k++) rx_case(k);
      tx_case(0);
      tx_case(1);
    end
    i_speed_100 = 1'b1;
    i_invalid_code_test = 1'b1;
    tx_case(1);
    i_invalid_code_test = 1'b0;
    check("rx_buffer_full", 8'(full_seen > 0), 8'h01);
    i_receive_tristate_request = 1'b1;
    repeat (5) @(posedge i_clk);
    #1 check("rx_oe_off", 8'(o_rx_oe), 8'h00);
    i_receive_tristate_request = 1'b0;
    repeat (5) @(posedge i_clk);
    #1 check("rx_oe_on", 8'(o_rx_oe), 8'h01);
    // Clock enable low: clocks and outputs hold, no symbol accepted
    i_ce = 1'b0;
    per = int'({o_txclk, o_rxclk, o_tx_sym});
    repeat (9) @(posedge i_clk);
    #1 check("ce_hold", 8'({o_txclk, o_rxclk, o_tx_sym}), 8'(per));
    check("ce_ready", 8'(o_rx_sym_ready), 8'h00);
    i_ce = 1'b1;
    i_link_up = 1'b0;
    measure(1, per);
    check("rxclk_local", 8'(per), 8'h04);
    report_and_stop();
  end

  // Watchdog against a hang
  initial
  begin
    #500000;
    miscompares++;
    report_and_stop();
  end
endmodule
